// file: rtl/rsa_consts.vh
// constants for the supervisor, alarm and interrupt block
`ifndef RSA_CONSTS_VH
`define RSA_CONSTS_VH

// register offsets
`define RSA_ADDR_ADJUST 4'h7
`define RSA_ADDR_CTRL1 4'hE
`define RSA_ADDR_CTRL2 4'hF

// interrupt_enable_control fields
`define RSA_C1_WK_EN 7
`define RSA_C1_DAY_EN 6
`define RSA_C1_H24 5
`define RSA_C1_CLKB_N 4
`define RSA_C1_TEST 3
`define RSA_C1_CT_HI 2
`define RSA_C1_CT_LO 0

// status_flag_control fields
`define RSA_C2_VSEL 7
`define RSA_C2_VDROP 6
`define RSA_C2_OSC 5
`define RSA_C2_PWR 4
`define RSA_C2_CLKA_N 3
`define RSA_C2_PFLAG 2
`define RSA_C2_WFLAG 1
`define RSA_C2_DFLAG 0

// reset values
`define RSA_RST_ADJUST 8'h00
`define RSA_RST_CTRL1 8'h00
`define RSA_RST_CTRL2 8'h10

// period select codes
`define RSA_CT_OFF 3'h0
`define RSA_CT_LOW 3'h1
`define RSA_CT_2HZ 3'h2
`define RSA_CT_1HZ 3'h3
`define RSA_CT_SEC 3'h4
`define RSA_CT_MIN 3'h5
`define RSA_CT_HOUR 3'h6
`define RSA_CT_MONTH 3'h7

// timing: sample window in microseconds, clock in MHz
`define RSA_WIN_US 7800
`define RSA_CLK_MHZ 125
`define RSA_WIN_CYC (`RSA_WIN_US * `RSA_CLK_MHZ)

`endif

// file: rtl/rsa_supervisor.v
// supervisor flags, supply monitor, alarm and periodic interrupt merge
//
// Behaviour
// - power-up reset clears control and adjustment registers, power flag set
// - power flag reads 1, cleared only by 0
// - oscillator flag low on halt, writable both ways
// - power flag high holds control bits at zero
// - threshold 2.1 V when select 0, else 1.3 V
// - monitor samples one 7.8 ms window per second
// - sampling stops while supply-drop flag is set
// - weekday and daily alarms compare counters, pull irq
// - weekday enable bit 7, daily bit 6
// - periodic, weekday, daily flags at bits 2,1,0
// - alarm flag write 1 ignored, 0 clears
// - clearing flag keeps enable, alarm stays armed
// - period select drives periodic irq, 000 disables
// - all enables zero releases irq high
// - irq low when any source asserts
// - halt sensing only while chip enable low
// - periodic flag clear in level mode releases irq
`include "rsa_consts.vh"
`default_nettype none

module rsa_supervisor #(
  parameter [19:0] WIN_CYCLES = `RSA_WIN_CYC
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire chip_enable,
  input wire osc_halt_seen,
  input wire vdd_below_2v1,
  input wire vdd_below_1v3,
  input wire tick_sec,
  input wire tick_min,
  input wire tick_hour,
  input wire tick_month,
  input wire wave_2hz,
  input wire wave_1hz,
  input wire [2:0] cnt_weekday,
  input wire [7:0] cnt_hour,
  input wire [7:0] cnt_minute,
  input wire [6:0] wk_alarm_days,
  input wire [7:0] wk_alarm_hour,
  input wire [7:0] wk_alarm_minute,
  input wire [7:0] day_alarm_hour,
  input wire [7:0] day_alarm_minute,
  input wire irq_out_n_in,
  output reg irq_out_n_out,
  output reg irq_out_n_oe,
  output reg [7:0] adjust_reg,
  output reg [7:0] interrupt_enable_control,
  output reg [7:0] status_flag_control
);

  ////////////////////////////////////////////////////////////////////////////
  // field views

  wire power_up_flag;
  wire osc_running_flag;
  wire supply_drop_flag;
  wire threshold_select;
  wire periodic_flag;
  wire weekday_alarm_flag;
  wire daily_alarm_flag;
  wire weekday_alarm_enable;
  wire daily_alarm_enable;
  wire [2:0] period_select;

  assign power_up_flag = status_flag_control[`RSA_C2_PWR];
  assign osc_running_flag = status_flag_control[`RSA_C2_OSC];
  assign supply_drop_flag = status_flag_control[`RSA_C2_VDROP];
  assign threshold_select = status_flag_control[`RSA_C2_VSEL];
  assign periodic_flag = status_flag_control[`RSA_C2_PFLAG];
  assign weekday_alarm_flag = status_flag_control[`RSA_C2_WFLAG];
  assign daily_alarm_flag = status_flag_control[`RSA_C2_DFLAG];
  assign weekday_alarm_enable = interrupt_enable_control[`RSA_C1_WK_EN];
  assign daily_alarm_enable = interrupt_enable_control[`RSA_C1_DAY_EN];
  assign period_select = interrupt_enable_control[`RSA_C1_CT_HI:`RSA_C1_CT_LO];

  wire irq_in_unused;
  assign irq_in_unused = irq_out_n_in;

  ////////////////////////////////////////////////////////////////////////////
  // write decode

  wire wr_adj;
  wire wr_c1;
  wire wr_c2;

  assign wr_adj = reg_wr && (reg_addr == `RSA_ADDR_ADJUST);
  assign wr_c1 = reg_wr && (reg_addr == `RSA_ADDR_CTRL1);
  assign wr_c2 = reg_wr && (reg_addr == `RSA_ADDR_CTRL2);

  // power flag after this cycle: only a written 0 clears it
  wire next_pwr;
  assign next_pwr = (wr_c2 && !reg_wdata[`RSA_C2_PWR]) ? 1'b0 : power_up_flag;

  ////////////////////////////////////////////////////////////////////////////
  // supply monitor window

  reg [19:0] win_cnt;
  reg win_open;
  wire below_thr;

  assign below_thr = threshold_select ? vdd_below_1v3 : vdd_below_2v1;

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      win_cnt <= 20'h0_0000;
      win_open <= 1'b0;
    end
    else if (supply_drop_flag)
    begin
      win_cnt <= 20'h0_0000;
      win_open <= 1'b0;
    end
    else if (tick_sec && !win_open)
    begin
      win_cnt <= WIN_CYCLES - 20'h0_0001;
      win_open <= 1'b1;
    end
    else if (win_open)
    begin
      if (win_cnt == 20'h0_0000)
      begin
        win_open <= 1'b0;
      end
      else
      begin
        win_cnt <= win_cnt - 20'h0_0001;
      end
    end
  end

  wire drop_set;
  assign drop_set = win_open && below_thr && !supply_drop_flag;

  ////////////////////////////////////////////////////////////////////////////
  // alarm compare

  wire wk_match;
  wire day_match;
  wire wk_set;
  wire day_set;

  assign wk_match = wk_alarm_days[cnt_weekday] && (cnt_hour == wk_alarm_hour)
    && (cnt_minute == wk_alarm_minute);
  assign day_match = (cnt_hour == day_alarm_hour)
    && (cnt_minute == day_alarm_minute);
  assign wk_set = tick_min && wk_match && weekday_alarm_enable;
  assign day_set = tick_min && day_match && daily_alarm_enable;

  ////////////////////////////////////////////////////////////////////////////
  // periodic event select

  reg per_event;
  reg per_pin_low;

  always @*
  begin
    per_event = 1'b0;
    per_pin_low = 1'b0;
    case (period_select)
      `RSA_CT_OFF:
      begin
        per_event = 1'b0;
        per_pin_low = 1'b0;
      end
      `RSA_CT_LOW:
      begin
        per_event = 1'b0;
        per_pin_low = 1'b1;
      end
      `RSA_CT_2HZ:
      begin
        per_event = !wave_2hz;
        per_pin_low = !wave_2hz;
      end
      `RSA_CT_1HZ:
      begin
        per_event = !wave_1hz;
        per_pin_low = !wave_1hz;
      end
      `RSA_CT_SEC:
      begin
        per_event = tick_sec;
        per_pin_low = periodic_flag;
      end
      `RSA_CT_MIN:
      begin
        per_event = tick_min;
        per_pin_low = periodic_flag;
      end
      `RSA_CT_HOUR:
      begin
        per_event = tick_hour;
        per_pin_low = periodic_flag;
      end
      `RSA_CT_MONTH:
      begin
        per_event = tick_month;
        per_pin_low = periodic_flag;
      end
      default:
      begin
        per_event = 1'b0;
        per_pin_low = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next register values

  reg [7:0] next_c1;
  reg [7:0] next_c2;
  reg [7:0] next_adj;

  always @*
  begin
    next_adj = adjust_reg;
    next_c1 = interrupt_enable_control;
    next_c2 = status_flag_control;
    if (wr_adj)
    begin
      next_adj = reg_wdata;
    end
    if (wr_c1)
    begin
      next_c1 = reg_wdata;
    end
    if (wr_c2)
    begin
      next_c2[`RSA_C2_VSEL] = reg_wdata[`RSA_C2_VSEL];
      next_c2[`RSA_C2_CLKA_N] = reg_wdata[`RSA_C2_CLKA_N];
      next_c2[`RSA_C2_OSC] = reg_wdata[`RSA_C2_OSC];
      // flags accept only a clearing 0
      next_c2[`RSA_C2_VDROP] = supply_drop_flag && reg_wdata[`RSA_C2_VDROP];
      next_c2[`RSA_C2_PFLAG] = periodic_flag && reg_wdata[`RSA_C2_PFLAG];
      next_c2[`RSA_C2_WFLAG] = weekday_alarm_flag && reg_wdata[`RSA_C2_WFLAG];
      next_c2[`RSA_C2_DFLAG] = daily_alarm_flag && reg_wdata[`RSA_C2_DFLAG];
    end
    next_c2[`RSA_C2_PWR] = next_pwr;
    // hardware sets win over a same-cycle clear
    if (drop_set)
    begin
      next_c2[`RSA_C2_VDROP] = 1'b1;
    end
    if (osc_halt_seen && !chip_enable)
    begin
      next_c2[`RSA_C2_OSC] = 1'b0;
    end
    if (per_event)
    begin
      next_c2[`RSA_C2_PFLAG] = 1'b1;
    end
    if (wk_set)
    begin
      next_c2[`RSA_C2_WFLAG] = 1'b1;
    end
    if (day_set)
    begin
      next_c2[`RSA_C2_DFLAG] = 1'b1;
    end
    // power flag pins the control bits and all flags but the oscillator and power flags at zero
    if (next_pwr)
    begin
      next_adj = 8'h00;
      next_c1 = 8'h00;
      next_c2[`RSA_C2_VSEL] = 1'b0;
      next_c2[`RSA_C2_VDROP] = 1'b0;
      next_c2[`RSA_C2_CLKA_N] = 1'b0;
      next_c2[`RSA_C2_PFLAG] = 1'b0;
      next_c2[`RSA_C2_WFLAG] = 1'b0;
      next_c2[`RSA_C2_DFLAG] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      adjust_reg <= `RSA_RST_ADJUST;
      interrupt_enable_control <= `RSA_RST_CTRL1;
      status_flag_control <= `RSA_RST_CTRL2;
    end
    else
    begin
      adjust_reg <= next_adj;
      interrupt_enable_control <= next_c1;
      status_flag_control <= next_c2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `RSA_ADDR_ADJUST:
        begin
          reg_rdata <= adjust_reg;
        end
        `RSA_ADDR_CTRL1:
        begin
          reg_rdata <= interrupt_enable_control;
        end
        `RSA_ADDR_CTRL2:
        begin
          reg_rdata <= status_flag_control;
        end
        default:
        begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin merge, open drain

  wire wk_low;
  wire day_low;
  wire any_low;

  assign wk_low = weekday_alarm_flag && weekday_alarm_enable;
  assign day_low = daily_alarm_flag && daily_alarm_enable;
  assign any_low = wk_low || day_low || per_pin_low;

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_out_n_out <= 1'b0;
      irq_out_n_oe <= 1'b0;
    end
    else
    begin
      irq_out_n_out <= 1'b0;
      irq_out_n_oe <= any_low;
    end
  end

endmodule // rsa_supervisor

`default_nettype wire

// file: bench/rsa_host.sv
// host model driving the register port
`default_nettype none
module rsa_host (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge core_clk);
    reg_wr = 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge core_clk);
    reg_rd = 1'h0;
    d = reg_rdata;
  endtask
endmodule // rsa_host
`default_nettype wire

// file: bench/rsa_supervisor_properties.sv
// concurrent checks on the supervisor ports
`default_nettype none
module rsa_props #(
  parameter [19:0] WIN_CYCLES = 20'h0_0014
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic chip_enable,
  input wire logic osc_halt_seen,
  input wire logic vdd_below_2v1,
  input wire logic vdd_below_1v3,
  input wire logic tick_min,
  input wire logic irq_out_n_oe,
  input wire logic [7:0] adjust_reg,
  input wire logic [7:0] interrupt_enable_control,
  input wire logic [7:0] status_flag_control
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [7:0] sf = status_flag_control;
  wire [7:0] ie = interrupt_enable_control;
  wire wf = reg_wr && reg_addr == 4'hF;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////
  a_power_holds_zero: assert property (sf[4] |-> ie == 8'h00 && adjust_reg == 8'h00
    && (sf & 8'hCF) == 8'h00) else $error("control bits not held at zero");
  a_power_write_zero: assert property (wf && !reg_wdata[4] |=> !sf[4])
    else $error("power flag not cleared by write");
  a_power_stays_clear: assert property (!sf[4] |=> !sf[4])
    else $error("power flag set without reset");
  a_osc_write_one: assert property (wf && reg_wdata[5] && !osc_halt_seen |=> sf[5])
    else $error("oscillator flag not written to one");
  a_osc_ce_high: assert property (chip_enable && sf[5] && !reg_wr |=> sf[5])
    else $error("halt sensed while chip enable high");
  a_drop_cause: assert property ($rose(sf[6])
    |-> $past(sf[7] ? vdd_below_1v3 : vdd_below_2v1)) else $error("drop flag without cause");
  a_drop_holds: assert property (sf[6] && !reg_wr |=> sf[6])
    else $error("drop flag cleared by itself");
  a_alarm_cause: assert property ($rose(sf[1]) |-> $past(tick_min && ie[7]))
    else $error("weekday flag set without enabled match");
  a_alarm_clear: assert property (wf && !reg_wdata[1] && !tick_min |=> !sf[1])
    else $error("weekday flag not cleared");
  a_irq_alarm_low: assert property (((sf[1] && ie[7]) || (sf[0] && ie[6]))[*2]
    |-> irq_out_n_oe) else $error("alarm not driving irq");
  a_irq_idle_high: assert property ((ie[7:6] == 2'h0 && ie[2:0] == 3'h0)[*2]
    |-> !irq_out_n_oe) else $error("irq driven with all sources off");
endmodule // rsa_props
bind rsa_supervisor rsa_props #(.WIN_CYCLES(WIN_CYCLES)) u_props (.core_clk, .sys_rst,
  .reg_addr, .reg_wdata, .reg_wr, .chip_enable, .osc_halt_seen, .vdd_below_2v1,
  .vdd_below_1v3, .tick_min, .irq_out_n_oe, .adjust_reg, .interrupt_enable_control,
  .status_flag_control);
`default_nettype wire

// file: bench/rsa_supervisor_test.sv
// self-checking bench for the supervisor block
`default_nettype none
module rsa_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic ce = 1'h0, halt = 1'h0, v2 = 1'h0, v1 = 1'h0, reg_wr, reg_rd, irq_out_n_oe;
  logic [3:0] tk = 4'h0;
  logic [1:0] wv = 2'h3;
  logic [2:0] wd = 3'h3;
  logic [7:0] hr = 8'h12, mn = 8'h34, dm = 8'h34, reg_wdata, reg_rdata, rd_v;
  logic [7:0] o_adj, o_c1, o_c2;
  logic [6:0] wm = 7'h08;
  logic irq_o;
  logic [3:0] reg_addr;
  // open-drain pin with its pull-up
  wire irq_pin = irq_out_n_oe ? irq_o : 1'h1;
  int err_count = 0, checks_done = 0, cyc = 0, i;
  rsa_host h (.core_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  rsa_supervisor #(.WIN_CYCLES(20'h0_0014)) DUT (.core_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chip_enable(ce), .osc_halt_seen(halt),
    .vdd_below_2v1(v2), .vdd_below_1v3(v1), .tick_sec(tk[0]), .tick_min(tk[1]),
    .tick_hour(tk[2]), .tick_month(tk[3]), .wave_2hz(wv[0]), .wave_1hz(wv[1]),
    .cnt_weekday(wd), .cnt_hour(hr), .cnt_minute(mn), .wk_alarm_days(wm),
    .wk_alarm_hour(8'h12), .wk_alarm_minute(8'h34), .day_alarm_hour(8'h12),
    .day_alarm_minute(dm), .irq_out_n_in(irq_pin), .irq_out_n_out(irq_o), .irq_out_n_oe,
    .adjust_reg(o_adj), .interrupt_enable_control(o_c1), .status_flag_control(o_c2));
  always #4 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h got %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    h.rd(a, rd_v);
    chk($sformatf("register %h", a), e, rd_v);
  endtask
  task automatic pc(input int n, input logic e);
    repeat (n) @(negedge core_clk);
    chk("irq pin", {7'h00, e}, {7'h00, irq_pin});
  endtask
  task automatic pl(input int k);
    @(negedge core_clk);
    tk[k] = 1'h1;
    @(negedge core_clk);
    tk[k] = 1'h0;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(negedge core_clk);
    sys_rst = 1'h0;
    rc(4'h7, 8'h00);
    rc(4'hE, 8'h00);
    rc(4'hF, 8'h10);
    rc(4'h3, 8'h00);
    h.wr(4'hE, 8'hFF);
    h.wr(4'h7, 8'hFF);
    h.wr(4'hF, 8'hFF);
    rc(4'hE, 8'h00);
    rc(4'h7, 8'h00);
    rc(4'hF, 8'h30);
    h.wr(4'hF, 8'h20);
    h.wr(4'h7, 8'h5A);
    rc(4'h7, 8'h5A);
    rc(4'hF, 8'h20);
    ce = 1'h1;
    halt = 1'h1;
    rc(4'hF, 8'h20);
    ce = 1'h0;
    rc(4'hF, 8'h00);
    halt = 1'h0;
    h.wr(4'hF, 8'h20);
    h.wr(4'hE, 8'h80);
    pl(1);
    pc(2, 1'h0);
    rc(4'hF, 8'h22);
    h.wr(4'hF, 8'h23);
    rc(4'hF, 8'h22);
    h.wr(4'hF, 8'h20);
    pc(2, 1'h1);
    rc(4'hE, 8'h80);
    pl(1);
    rc(4'hF, 8'h22);
    h.wr(4'hE, 8'hC0);
    pl(1);
    rc(4'hF, 8'h23);
    h.wr(4'hF, 8'h22);
    pc(2, 1'h0);
    h.wr(4'hE, 8'h00);
    h.wr(4'hF, 8'h20);
    pc(2, 1'h1);
    pl(1);
    rc(4'hF, 8'h20);
    mn = 8'h35;
    h.wr(4'hE, 8'hC0);
    pl(1);
    rc(4'hF, 8'h20);
    h.wr(4'hE, 8'h00);
    // presets move only while both alarms are off
    dm = 8'h35;
    wd = 3'h2;
    h.wr(4'hE, 8'hC0);
    pl(1);
    rc(4'hF, 8'h21);
    h.wr(4'hE, 8'h00);
    wm = 7'h04;
    mn = 8'h34;
    h.wr(4'hE, 8'hC0);
    h.wr(4'hF, 8'h20);
    pl(1);
    rc(4'hF, 8'h22);
    h.wr(4'hE, 8'h00);
    h.wr(4'hF, 8'h20);
    for (i = 4; i < 8; i++)
    begin
      h.wr(4'hE, 8'(i));
      pl(i - 4);
      pc(2, 1'h0);
      rc(4'hF, 8'h24);
      h.wr(4'hF, 8'h20);
      pc(2, 1'h1);
    end
    for (i = 2; i < 4; i++)
    begin
      h.wr(4'hE, 8'(i));
      pc(3, 1'h1);
      wv[i - 2] = 1'h0;
      pc(3, 1'h0);
      wv[i - 2] = 1'h1;
    end
    h.wr(4'hE, 8'h01);
    pc(3, 1'h0);
    h.wr(4'hE, 8'h00);
    h.wr(4'hF, 8'h20);
    pc(3, 1'h1);
    h.wr(4'hF, 8'hA0);
    v2 = 1'h1;
    pl(0);
    repeat (25) @(negedge core_clk);
    rc(4'hF, 8'hA0);
    h.wr(4'hF, 8'h20);
    rc(4'hF, 8'h20);
    pl(0);
    rc(4'hF, 8'h60);
    h.wr(4'hF, 8'h20);
    rc(4'hF, 8'h20);
    h.wr(4'hE, 8'h80);
    chk("ctrl1 port", 8'h80, o_c1);
    chk("status port", 8'h20, o_c2);
    chk("adjust port", 8'h5A, o_adj);
    // second power-up in mid-run
    sys_rst = 1'h1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'h0;
    chk("ctrl1 port", 8'h00, o_c1);
    chk("status port", 8'h10, o_c2);
    chk("adjust port", 8'h00, o_adj);
    rc(4'hE, 8'h00);
    rc(4'hF, 8'h10);
    summarize();
  end
endmodule // rsa_supervisor_test
`default_nettype wire
